// >>> rtl/regulator_vsel_pkg.sv
// Purpose: shared constants for the regulator start-up and current-limit block
// Assumes: 10 MHz clock, AXI4-Lite register access, word index = byte address / 4
// Notes: channel order everywhere is buck1, buck2, linreg1, linreg2
package regulator_vsel_pkg;

  localparam int NCH = 4;
  localparam int CODE_W = 7;
  localparam int ADDR_W = 12;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_LINREG1_CODE = 8'h41;
  localparam logic [7:0] IDX_LINREG2_CODE = 8'h42;
  localparam logic [7:0] IDX_BUCK1_CODE = 8'h46;
  localparam logic [7:0] IDX_BUCK1_LIMIT = 8'h47;
  localparam logic [7:0] IDX_BUCK2_CODE = 8'h48;
  localparam logic [7:0] IDX_BUCK2_LIMIT = 8'h49;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h50;
  localparam logic [7:0] IDX_STARTUP_STAT = 8'h51;

  // limit register fields
  localparam int HIGH_LIM_BIT = 7;
  localparam int IDLE_LIM_LSB = 8;
  localparam int IDLE_LIM_MSB = 9;

  // per-channel code widths: 7-bit buck codes, 5-bit linear regulator codes
  localparam logic [6:0] CODE_MIN [NCH] = '{7'h00, 7'h00, 7'h00, 7'h00};
  localparam logic [6:0] CODE_MAX [NCH] = '{7'h7F, 7'h7F, 7'h1F, 7'h1F};
  // strap tied low: 1.2 V, 2.8 V, 1.2 V, 1.8 V
  localparam logic [6:0] LOW_DEFAULT [NCH] = '{7'h0E, 7'h4E, 7'h06, 7'h10};
  // strap tied to 2.4 V: 1.35 V, 3.3 V, 1.35 V, 3.3 V
  localparam logic [6:0] HIGH_DEFAULT [NCH] = '{7'h14, 7'h62, 7'h09, 7'h1F};

  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_HIGH = 2'b01,
    STRAP_DIVIDER = 2'b10
  } strap_t;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_HIBERNATE = 2'b10
  } buck_mode_t;

  // applied limit: 0..3 standby low table, 4..7 standby high table,
  // 8 = 600 mA active, 9 = 1000 mA active, 10 = fixed hibernate limit
  localparam logic [3:0] LIM_ACTIVE_600 = 4'h8;
  localparam logic [3:0] LIM_ACTIVE_1000 = 4'h9;
  localparam logic [3:0] LIM_HIBERNATE = 4'hA;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_SEARCH = 2'b11,
    ST_DONE = 2'b10
  } seq_state_t;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CYC = SETTLE_CYC_I[7:0];

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> rtl/regulator_vsel_startup_and_limits.sv
// Purpose: start-up level-code resolution from strap pins and buck current-limit select
// Assumes: strap class and comparator inputs are synchronous to clk
// Notes: level codes are searched in parallel; software owns them once supplies are ok
`timescale 1ns/1ns

// Summary of operation
// RULE_01: buck level codes are 7 bits, 25 mV per step, top code 4.025 V.
// RULE_02: at start-up sample each strap pin and load the matching level code.
// RULE_03: after start-up and supplies ok, straps are ignored; software owns codes.
// RULE_04: strap low loads 1.2, 2.8, 1.2 and 1.8 V defaults.
// RULE_05: strap high loads 1.35, 3.3, 1.35 and 3.3 V defaults.
// RULE_06: divider strap starts at the lowest code and steps upward.
// RULE_07: stepping stops and the code is kept when the comparator trips.
// RULE_08: board must keep divider targets below the top code range.
// RULE_09: software should rewrite all level codes soon after start-up.
// RULE_10: high-limit bit 7 resets to 0: 0 selects 600 mA, 1 selects 1000 mA.
// RULE_11: idle-limit field bits 9:8 resets to 00: 70/150/300/600 mA.
// RULE_12: with high-limit set the idle codes give 110/220/450/900 mA.
// RULE_13: active mode uses high-limit bit; standby uses idle field with it.
// RULE_14: hibernate applies a fixed limit, ignoring both limit fields.
// RULE_15: software should set the high limit only for brief heavy loads.
// RULE_16: buck code zero is 0.85 V, each step adds 25 mV.
// RULE_17: linear regulator codes are 5 bits, searched in table order.
// RULE_18: wait a settling time after each step; never pass the top code.
module regulator_vsel_startup_and_limits (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] buck1_strap_pin,
  input wire logic [1:0] buck2_strap_pin,
  input wire logic [1:0] linreg1_strap_pin,
  input wire logic [1:0] linreg2_strap_pin,
  input wire logic [3:0] strap_reached,
  output logic [6:0] buck1_level_code,
  output logic [6:0] buck2_level_code,
  output logic [4:0] linreg1_level_code,
  output logic [4:0] linreg2_level_code,
  output logic [3:0] buck1_limit_sel,
  output logic [3:0] buck2_limit_sel,
  output logic supplies_ok_out
);

  localparam int NCH = regulator_vsel_pkg::NCH;

  regulator_vsel_pkg::seq_state_t state_r;
  regulator_vsel_pkg::seq_state_t state_nxt;

  logic [6:0] code_r [NCH];
  logic [7:0] settle_r [NCH];
  logic [NCH-1:0] divider_r;
  logic [NCH-1:0] found_r;
  logic [NCH-1:0] overrun_r;
  logic [1:0] strap_in [NCH];

  logic buck1_high_r;
  logic buck2_high_r;
  logic [1:0] buck1_idle_r;
  logic [1:0] buck2_idle_r;
  logic [3:0] mode_r;

  // write channel holding registers
  logic [11:0] aw_addr_r;
  logic aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_held_r;

  assign strap_in[0] = buck1_strap_pin;
  assign strap_in[1] = buck2_strap_pin;
  assign strap_in[2] = linreg1_strap_pin;
  assign strap_in[3] = linreg2_strap_pin;

  // ---------------- start-up sequencer ----------------
  // straps are read once, in the sample state; later pin changes have no effect
  wire all_found = &found_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      regulator_vsel_pkg::ST_IDLE: state_nxt = regulator_vsel_pkg::ST_SAMPLE;
      regulator_vsel_pkg::ST_SAMPLE: state_nxt = regulator_vsel_pkg::ST_SEARCH;
      regulator_vsel_pkg::ST_SEARCH: begin
        if (all_found) begin
          state_nxt = regulator_vsel_pkg::ST_DONE;
        end
      end
      default: state_nxt = regulator_vsel_pkg::ST_DONE;
    endcase
  end

  wire in_sample = (state_r == regulator_vsel_pkg::ST_SAMPLE);
  wire in_search = (state_r == regulator_vsel_pkg::ST_SEARCH);
  // straps lose all influence once done; only bus writes move codes
  wire sw_owned = (state_r == regulator_vsel_pkg::ST_DONE); // RULE_03

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= regulator_vsel_pkg::ST_IDLE;
      supplies_ok_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      supplies_ok_out <= (state_nxt == regulator_vsel_pkg::ST_DONE);
    end
  end

  // ---------------- register decode ----------------
  // only word indices are decoded; address bits 11:10 must be zero
  wire write_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [7:0] w_idx = aw_addr_r[9:2];
  wire w_upper_zero = (aw_addr_r[11:10] == 2'b00);
  wire [7:0] r_idx = s_axi_araddr[9:2];
  wire r_upper_zero = (s_axi_araddr[11:10] == 2'b00);

  wire [7:0] code_idx [NCH];
  assign code_idx[0] = regulator_vsel_pkg::IDX_BUCK1_CODE;
  assign code_idx[1] = regulator_vsel_pkg::IDX_BUCK2_CODE;
  assign code_idx[2] = regulator_vsel_pkg::IDX_LINREG1_CODE;
  assign code_idx[3] = regulator_vsel_pkg::IDX_LINREG2_CODE;

  wire wr_lim1 = write_go && w_upper_zero && (w_idx == regulator_vsel_pkg::IDX_BUCK1_LIMIT);
  wire wr_lim2 = write_go && w_upper_zero && (w_idx == regulator_vsel_pkg::IDX_BUCK2_LIMIT);
  wire wr_mode = write_go && w_upper_zero && (w_idx == regulator_vsel_pkg::IDX_MODE_CTRL);
  wire w_known = w_upper_zero && ((w_idx == code_idx[0]) || (w_idx == code_idx[1])
    || (w_idx == code_idx[2]) || (w_idx == code_idx[3])
    || (w_idx == regulator_vsel_pkg::IDX_BUCK1_LIMIT)
    || (w_idx == regulator_vsel_pkg::IDX_BUCK2_LIMIT)
    || (w_idx == regulator_vsel_pkg::IDX_MODE_CTRL)
    || (w_idx == regulator_vsel_pkg::IDX_STARTUP_STAT));

  // ---------------- per-channel level code search ----------------
  // the settle count reloads on every step so the comparator only sees a steady output
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      wire wr_code = write_go && w_upper_zero && (w_idx == code_idx[gi]) && w_strb_r[0];
      wire at_max = (code_r[gi] == regulator_vsel_pkg::CODE_MAX[gi]);
      wire [6:0] code_step = code_r[gi] + 7'h01;
      wire [6:0] sw_code = w_data_r[6:0] & regulator_vsel_pkg::CODE_MAX[gi];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          code_r[gi] <= regulator_vsel_pkg::CODE_MIN[gi];
          settle_r[gi] <= 8'h00;
          divider_r[gi] <= 1'b0;
          found_r[gi] <= 1'b0;
          overrun_r[gi] <= 1'b0;
        end else if (in_sample) begin
          divider_r[gi] <= (strap_in[gi] == regulator_vsel_pkg::STRAP_DIVIDER);
          found_r[gi] <= (strap_in[gi] != regulator_vsel_pkg::STRAP_DIVIDER);
          settle_r[gi] <= regulator_vsel_pkg::SETTLE_CYC; // RULE_18
          if (strap_in[gi] == regulator_vsel_pkg::STRAP_HIGH) begin
            code_r[gi] <= regulator_vsel_pkg::HIGH_DEFAULT[gi]; // RULE_05
          end else if (strap_in[gi] == regulator_vsel_pkg::STRAP_LOW) begin
            code_r[gi] <= regulator_vsel_pkg::LOW_DEFAULT[gi]; // RULE_04
          end else begin
            code_r[gi] <= regulator_vsel_pkg::CODE_MIN[gi]; // RULE_06
          end
        end else if (in_search && !found_r[gi]) begin
          if (settle_r[gi] != 8'h00) begin
            settle_r[gi] <= settle_r[gi] - 8'h01; // RULE_18
          end else if (strap_reached[gi]) begin
            found_r[gi] <= 1'b1; // RULE_07
          end else if (at_max) begin
            // divider set too high; park at the top code instead of wrapping
            found_r[gi] <= 1'b1; // RULE_18
            overrun_r[gi] <= 1'b1;
          end else begin
            code_r[gi] <= code_step; // RULE_06 RULE_17 RULE_01 RULE_16
            settle_r[gi] <= regulator_vsel_pkg::SETTLE_CYC;
          end
        end else if (sw_owned && wr_code) begin
          code_r[gi] <= sw_code; // RULE_03
        end
      end
    end
  endgenerate

  // ---------------- current limit registers ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck1_high_r <= 1'b0; // RULE_10
      buck2_high_r <= 1'b0;
      buck1_idle_r <= 2'b00; // RULE_11
      buck2_idle_r <= 2'b00;
      mode_r <= 4'h0;
    end else begin
      if (wr_lim1 && w_strb_r[0]) begin
        buck1_high_r <= w_data_r[regulator_vsel_pkg::HIGH_LIM_BIT];
      end
      if (wr_lim1 && w_strb_r[1]) begin
        buck1_idle_r <= w_data_r[regulator_vsel_pkg::IDLE_LIM_MSB:regulator_vsel_pkg::IDLE_LIM_LSB];
      end
      if (wr_lim2 && w_strb_r[0]) begin
        buck2_high_r <= w_data_r[regulator_vsel_pkg::HIGH_LIM_BIT];
      end
      if (wr_lim2 && w_strb_r[1]) begin
        buck2_idle_r <= w_data_r[regulator_vsel_pkg::IDLE_LIM_MSB:regulator_vsel_pkg::IDLE_LIM_LSB];
      end
      if (wr_mode && w_strb_r[0]) begin
        mode_r <= w_data_r[3:0];
      end
    end
  end

  // modes 10 and 11 both fall through to the fixed hibernate limit
  function automatic logic [3:0] limit_pick(input logic [1:0] mode, input logic high,
                                            input logic [1:0] idle);
    logic [3:0] sel;
    sel = regulator_vsel_pkg::LIM_HIBERNATE; // RULE_14
    if (mode == regulator_vsel_pkg::MODE_ACTIVE) begin
      sel = high ? regulator_vsel_pkg::LIM_ACTIVE_1000 : regulator_vsel_pkg::LIM_ACTIVE_600;
    end else if (mode == regulator_vsel_pkg::MODE_STANDBY) begin
      sel = {1'b0, high, idle}; // RULE_11 RULE_12
    end
    return sel;
  endfunction

  wire [3:0] buck1_lim_nxt = limit_pick(mode_r[1:0], buck1_high_r, buck1_idle_r); // RULE_13
  wire [3:0] buck2_lim_nxt = limit_pick(mode_r[3:2], buck2_high_r, buck2_idle_r); // RULE_13
  // level outputs lag the code register by one cycle; the comparator trips on them

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck1_limit_sel <= regulator_vsel_pkg::LIM_ACTIVE_600;
      buck2_limit_sel <= regulator_vsel_pkg::LIM_ACTIVE_600;
      buck1_level_code <= 7'h00;
      buck2_level_code <= 7'h00;
      linreg1_level_code <= 5'h00;
      linreg2_level_code <= 5'h00;
    end else begin
      buck1_limit_sel <= buck1_lim_nxt; // RULE_10
      buck2_limit_sel <= buck2_lim_nxt;
      buck1_level_code <= code_r[0]; // RULE_02
      buck2_level_code <= code_r[1];
      linreg1_level_code <= code_r[2][4:0];
      linreg2_level_code <= code_r[3][4:0];
    end
  end

  // ---------------- AXI4-Lite write path ----------------
  // aw and w are taken in either order; the response waits until both are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_addr_r <= 12'h000;
      aw_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= regulator_vsel_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_known ? regulator_vsel_pkg::RESP_OKAY : regulator_vsel_pkg::RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  // data is latched with the address, so rdata stands unchanged until rready
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = r_upper_zero;
    if (!r_upper_zero) begin
      rd_hit = 1'b0;
    end else if (r_idx == regulator_vsel_pkg::IDX_BUCK1_CODE) begin
      rd_word[6:0] = code_r[0];
    end else if (r_idx == regulator_vsel_pkg::IDX_BUCK2_CODE) begin
      rd_word[6:0] = code_r[1];
    end else if (r_idx == regulator_vsel_pkg::IDX_LINREG1_CODE) begin
      rd_word[6:0] = code_r[2];
    end else if (r_idx == regulator_vsel_pkg::IDX_LINREG2_CODE) begin
      rd_word[6:0] = code_r[3];
    end else if (r_idx == regulator_vsel_pkg::IDX_BUCK1_LIMIT) begin
      rd_word[9:7] = {buck1_idle_r, buck1_high_r};
    end else if (r_idx == regulator_vsel_pkg::IDX_BUCK2_LIMIT) begin
      rd_word[9:7] = {buck2_idle_r, buck2_high_r};
    end else if (r_idx == regulator_vsel_pkg::IDX_MODE_CTRL) begin
      rd_word[3:0] = mode_r;
    end else if (r_idx == regulator_vsel_pkg::IDX_STARTUP_STAT) begin
      rd_word[13:0] = {overrun_r, divider_r, found_r, in_search, sw_owned};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= regulator_vsel_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? regulator_vsel_pkg::RESP_OKAY : regulator_vsel_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// >>> test/regulator_vsel_properties.sv
// Purpose: port-level checks of start-up stepping and software ownership
// Assumes: one clock domain, reset active high
// Notes: attached by bind below
`timescale 1ns/1ns
module regulator_vsel_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] strap_reached,
  input wire logic [6:0] buck1_level_code,
  input wire logic [6:0] buck2_level_code,
  input wire logic [4:0] linreg1_level_code,
  input wire logic [4:0] linreg2_level_code,
  input wire logic [3:0] buck1_limit_sel,
  input wire logic [3:0] buck2_limit_sel,
  input wire logic supplies_ok_out
);
  wire [23:0] codes = {buck1_level_code, buck2_level_code, linreg1_level_code, linreg2_level_code};
  wire [7:0] lims = {buck1_limit_sel, buck2_limit_sel};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_vals;
    $fell(rst) |-> lims == 8'h88 && !supplies_ok_out;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("limits or ok wrong after reset");
  property p_ok_sticky;
    supplies_ok_out |=> supplies_ok_out;
  endproperty
  a_ok_sticky: assert property (p_ok_sticky) else $error("ok dropped");
  property p_code_sw;
    $past(supplies_ok_out, 3) && $changed(codes)
      |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_code_sw: assert property (p_code_sw) else $error("code moved without a write");
  property p_lim_sw;
    $changed(lims) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_lim_sw: assert property (p_lim_sw) else $error("limit moved without a write");
  property p_step;
    !supplies_ok_out && $changed(linreg1_level_code) && $past(linreg1_level_code) != 5'h00
      |-> linreg1_level_code == $past(linreg1_level_code) + 5'h01
      ##1 $stable(linreg1_level_code) [*8];
  endproperty
  a_step: assert property (p_step) else $error("search step wrong");
  property p_no_wrap;
    !supplies_ok_out && $past(linreg2_level_code) == 5'h1f |-> linreg2_level_code == 5'h1f;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("search left top code");
  property p_stop;
    !supplies_ok_out && $past(strap_reached[2]) && $past(linreg1_level_code) != 5'h00
      |-> $stable(linreg1_level_code);
  endproperty
  a_stop: assert property (p_stop) else $error("search went on after trip");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  // both halves taken at one edge: the response is registered one edge later still
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  c_ok: cover property ($rose(supplies_ok_out));
  c_step: cover property (!supplies_ok_out && $changed(linreg1_level_code));
  c_hib: cover property (buck1_limit_sel == regulator_vsel_pkg::LIM_HIBERNATE);
endmodule
bind regulator_vsel_startup_and_limits regulator_vsel_properties chk_i (.*);

// >>> test/tb_top.sv
// Purpose: self-checking bench for start-up code resolution and current limits
// Assumes: far-side model supplies straps and comparator
// Notes: one start-up breaks the divider limit on purpose to reach the top code
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, strap_reached, buck1_limit_sel, buck2_limit_sel;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] buck1_strap_pin, buck2_strap_pin, linreg1_strap_pin, linreg2_strap_pin;
  logic [6:0] buck1_level_code, buck2_level_code;
  logic [4:0] linreg1_level_code, linreg2_level_code;
  logic supplies_ok_out;
  logic [1:0] bresp_seen = 2'b00;
  logic [7:0] strap_cls = '0;
  logic [27:0] target = '0;
  logic [6:0] code [4];
  int n_fail = 0, comparisons = 0;
  int exp_code [4];
  localparam int LO_MV [4] = '{1200, 2800, 1200, 1800};
  localparam int HI_MV [4] = '{1350, 3300, 1350, 3300};
  localparam int MAXC [4] = '{127, 127, 31, 31};
  localparam logic [7:0] CIDX [4] = '{8'h46, 8'h48, 8'h41, 8'h42};
  assign code[0] = buck1_level_code;
  assign code[1] = buck2_level_code;
  assign code[2] = {2'b00, linreg1_level_code};
  assign code[3] = {2'b00, linreg2_level_code};
  regulator_vsel_startup_and_limits dut (.*);
  vsel_far_side far_i (.*);
  always #50 clk = ~clk;
  function automatic int vcode(int ch, int mv);
    if (ch < 2) return (mv - 850) / 25;
    if (mv <= 1600) return (mv - 900) / 50;
    return 14 + (mv - 1600) / 100;
  endfunction
  function automatic int lsel(int m, int v);
    if (m >= 2) return regulator_vsel_pkg::LIM_HIBERNATE;
    if (m == 1) return v;
    return 8 + (v >> 2);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hold valid until its own ready; a trailing edge keeps bready from two updates per step
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
      bresp_seen = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task startup(input logic [7:0] c, input logic [27:0] t);
    rst <= 1'b1;
    strap_cls <= c;
    target <= t;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    while (supplies_ok_out !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      if (!c[2*i+1]) exp_code[i] = vcode(i, c[2*i] ? HI_MV[i] : LO_MV[i]);
      else if (t[7*i+:7] > MAXC[i]) exp_code[i] = MAXC[i];
      else exp_code[i] = t[7*i+:7];
      chk(code[i], exp_code[i]);
    end
    $display("start-up case done");
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] w;
    void'($urandom(32'h3096_e837));
    startup(8'ha4, {7'h03, 7'h05, 7'h00, 7'h00});
    strap_cls <= 8'h55;
    repeat (300) @(posedge clk);
    for (int i = 0; i < 4; i++) chk(code[i], exp_code[i]);
    for (int i = 0; i < 4; i++) begin
      w = $urandom & MAXC[i];
      wr({2'b00, CIDX[i], 2'b00}, w);
      chk(bresp_seen, regulator_vsel_pkg::RESP_OKAY);
      chk(code[i], w);
      rd({2'b00, CIDX[i], 2'b00}, d, r);
      chk(d, w);
      chk(r, regulator_vsel_pkg::RESP_OKAY);
    end
    $display("software ownership done");
    rd(12'h11c, d, r);
    chk(d, 0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h140, m * 5);
      for (int v = 0; v < 8; v++) begin
        wr(12'h11c, ((v & 3) << 8) | ((v >> 2) << 7));
        wr(12'h124, (((7 - v) & 3) << 8) | (((7 - v) >> 2) << 7));
        chk(buck1_limit_sel, lsel(m, v));
        chk(buck2_limit_sel, lsel(m, 7 - v));
      end
    end
    rd(12'h11c, d, r);
    chk(d, 32'h0000_0380);
    rd(12'h3f0, d, r);
    chk(r, regulator_vsel_pkg::RESP_SLVERR);
    chk(d, 0);
    wr(12'h3f0, 32'h0000_0001);
    chk(bresp_seen, regulator_vsel_pkg::RESP_SLVERR);
    // heavy-load limit is dropped again once the burst is over
    wr(12'h140, 32'h0000_0000);
    wr(12'h11c, 32'h0000_0000);
    chk(buck1_limit_sel, regulator_vsel_pkg::LIM_ACTIVE_600);
    $display("limit select done");
    startup(8'h91, {7'h7f, 7'h00, 7'h00, 7'h00});
    startup(8'h4a, {7'h00, 7'h00, 7'h01, 7'h02});
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule

// >>> test/vsel_far_side.sv
// Purpose: far-side model: strap wiring and the per-channel divider comparator
// Assumes: straps follow strap_cls, set during reset and moved once by the bench after start-up
// Notes: target holds one 7-bit code per channel, buck1 in the low bits
`timescale 1ns/1ns
module vsel_far_side (
  input wire logic [7:0] strap_cls,
  input wire logic [27:0] target,
  input wire logic [6:0] buck1_level_code,
  input wire logic [6:0] buck2_level_code,
  input wire logic [4:0] linreg1_level_code,
  input wire logic [4:0] linreg2_level_code,
  output logic [1:0] buck1_strap_pin,
  output logic [1:0] buck2_strap_pin,
  output logic [1:0] linreg1_strap_pin,
  output logic [1:0] linreg2_strap_pin,
  output logic [3:0] strap_reached
);
  assign buck1_strap_pin = strap_cls[1:0];
  assign buck2_strap_pin = strap_cls[3:2];
  assign linreg1_strap_pin = strap_cls[5:4];
  assign linreg2_strap_pin = strap_cls[7:6];
  // divider node meets the reference once the output reaches the board's target;
  // a target past the top code is a board fault that some scenario commands
  assign strap_reached[0] = buck1_level_code >= target[6:0];
  assign strap_reached[1] = buck2_level_code >= target[13:7];
  assign strap_reached[2] = {2'b00, linreg1_level_code} >= target[20:14];
  assign strap_reached[3] = {2'b00, linreg2_level_code} >= target[27:21];
endmodule
